// ===== design/comparator_channel_pkg.sv
// Purpose: Shared constants for the comparator channel control block
// Assumes: APB with 32-bit data, two register words
// Notes: Field positions and codes of the channel configuration word
package comparator_channel_pkg;
  localparam logic [11:0] CFG_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int EXCHANGE_BIT = 15;
  localparam int PLUS_SEL_LSB = 12;
  localparam int MINUS_SEL_LSB = 8;
  localparam int TRIG_LSB = 5;
  localparam int SPEED_LSB = 2;
  localparam int ONE_SHOT_BIT = 1;
  localparam int ENABLE_BIT = 0;
  localparam int SYNC_STAGES = 2;
  localparam logic [2:0] MINUS_GROUND = 3'h4;
  localparam logic [2:0] MINUS_SUPPLY_FRACTION = 3'h5;
  localparam logic [2:0] MINUS_BANDGAP = 3'h6;
  localparam logic [2:0] MINUS_CONVERTER = 3'h7;
  localparam logic [1:0] TRIG_TOGGLE = 2'h0;
  localparam logic [1:0] TRIG_RISING = 2'h1;
  localparam logic [1:0] TRIG_FALLING = 2'h2;
  localparam logic [1:0] TRIG_END_OF_COMPARE = 2'h3;
  localparam logic [1:0] SPEED_LOW = 2'h0;
  localparam logic [1:0] SPEED_HIGH = 2'h1;
endpackage : comparator_channel_pkg

// ===== design/level_sync.sv
// Purpose: Two flip-flop synchroniser for one level
// Assumes: Single clock, async active-low reset
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps
module level_sync
#(
  parameter int STAGES = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_level,
  output logic sync_level
);
  logic [STAGES-1:0] chain;

  // Shift chain, last stage is the output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chain <= '0;
    else
      chain <= {chain[STAGES-2:0], async_level};
  end

  assign sync_level = chain[STAGES-1];
endmodule : level_sync

// ===== design/trigger_detect.sv
// Purpose: Trigger condition decoder for the comparator result
// Assumes: Result and done already in the core domain
// Notes: End-of-compare only fires in one-shot operation
`timescale 1ns/1ps
module trigger_detect
  import comparator_channel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic result,
  input wire logic compare_done,
  input wire logic one_shot,
  input wire logic [1:0] condition,
  output logic fire
);
  logic prev;
  logic rise;
  logic fall;

  // Remember last result, cleared while the channel is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev <= 1'b0;
    else if (!active)
      prev <= 1'b0;
    else
      prev <= result;
  end

  assign rise = active && result && !prev;
  assign fall = active && !result && prev;

  // Select the event
  always_comb
  begin
    case (condition)
      TRIG_TOGGLE: fire = rise || fall;
      TRIG_RISING: fire = rise;
      TRIG_FALLING: fire = fall;
      TRIG_END_OF_COMPARE: fire = active && one_shot && compare_done;
      default: fire = 1'b0;
    endcase
  end
endmodule : trigger_detect

// ===== design/comparator_channel_control.sv
// Purpose: Configuration and enable control of one comparator channel
// Assumes: APB slave, one clock; core clock arrives as enable pulses
// Notes: Enable passes a two-stage synchroniser with an acknowledge
`timescale 1ns/1ps
module comparator_channel_control
  import comparator_channel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_tick,
  input wire logic [3:0] pin_level_valid,
  input wire logic raw_compare,
  input wire logic compare_done,
  output logic [1:0] plus_input_select,
  output logic [2:0] minus_input_select,
  output logic positive_from_minus,
  output logic negative_from_plus,
  output logic [1:0] speed_select,
  output logic one_shot,
  output logic comparator_enable,
  output logic compare_result,
  output logic trigger_event
);
  import comparator_channel_pkg::*;

  logic exchange;
  logic [1:0] trigger_condition;
  logic enable_request;
  logic enable_state;
  logic core_req_sync;
  logic core_enable;
  logic ack_sync;
  logic write_access;
  logic read_access;
  logic addr_ok;
  logic cfg_hit;
  logic status_hit;
  logic locked;
  logic fire;
  logic [31:0] cfg_word;
  logic [31:0] next_prdata;

  // Bus decode, zero wait states
  assign write_access = psel && penable && pwrite;
  assign read_access = psel && !penable && !pwrite;
  assign cfg_hit = paddr == CFG_OFFSET;
  assign status_hit = paddr == STATUS_OFFSET;
  assign addr_ok = cfg_hit || status_hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Lock holds while enabled or a change is in flight
  assign locked = enable_request || enable_state;

  // Configuration fields, bus domain, no sync
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exchange <= CFG_RESET[EXCHANGE_BIT];
      plus_input_select <= CFG_RESET[PLUS_SEL_LSB +: 2];
      minus_input_select <= CFG_RESET[MINUS_SEL_LSB +: 3];
      trigger_condition <= CFG_RESET[TRIG_LSB +: 2];
      speed_select <= CFG_RESET[SPEED_LSB +: 2];
      one_shot <= CFG_RESET[ONE_SHOT_BIT];
    end
    else if (write_access && cfg_hit && !locked)
    begin
      if (pstrb[1])
      begin
        exchange <= pwdata[EXCHANGE_BIT];
        plus_input_select <= pwdata[PLUS_SEL_LSB +: 2];
        minus_input_select <= pwdata[MINUS_SEL_LSB +: 3];
      end
      if (pstrb[0])
      begin
        trigger_condition <= pwdata[TRIG_LSB +: 2];
        speed_select <= pwdata[SPEED_LSB +: 2];
        one_shot <= pwdata[ONE_SHOT_BIT];
      end
    end
  end

  // Requested enable, written any time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_request <= CFG_RESET[ENABLE_BIT];
    else if (write_access && cfg_hit && pstrb[0])
      enable_request <= pwdata[ENABLE_BIT];
  end

  // Request into core domain, two ticks of core clock
  logic [1:0] req_chain;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_chain <= 2'h0;
    else if (core_tick)
      req_chain <= {req_chain[0], enable_request};
  end
  assign core_req_sync = req_chain[1];

  // Core side applies request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_enable <= 1'b0;
    else if (core_tick)
      core_enable <= core_req_sync;
  end

  // Acknowledge back to bus side
  level_sync #(
    .STAGES(SYNC_STAGES)
  ) u_ack_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_level(core_enable),
    .sync_level(ack_sync)
  );

  // Readable enable follows completed action only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_state <= 1'b0;
    else
      enable_state <= ack_sync;
  end

  assign comparator_enable = core_enable;

  // Terminal routing, exchange swaps roles
  assign positive_from_minus = exchange;
  assign negative_from_plus = exchange;

  // Result inverted when exchanged, cleared while core_enable is low
  logic result_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_q <= 1'b0;
    else if (!core_enable)
      result_q <= 1'b0;
    else if (core_tick)
      result_q <= raw_compare ^ exchange;
  end
  assign compare_result = result_q;

  trigger_detect u_trigger (
    .pclk(pclk),
    .presetn(presetn),
    .active(core_enable),
    .result(raw_compare ^ exchange),
    .compare_done(compare_done),
    .one_shot(one_shot),
    .condition(trigger_condition),
    .fire(fire)
  );

  // Event output registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trigger_event <= 1'b0;
    else
      trigger_event <= fire;
  end

  // Read word, reserved bits zero
  always_comb
  begin
    cfg_word = 32'h0000_0000;
    cfg_word[EXCHANGE_BIT] = exchange;
    cfg_word[PLUS_SEL_LSB +: 2] = plus_input_select;
    cfg_word[MINUS_SEL_LSB +: 3] = minus_input_select;
    cfg_word[TRIG_LSB +: 2] = trigger_condition;
    cfg_word[SPEED_LSB +: 2] = speed_select;
    cfg_word[ONE_SHOT_BIT] = one_shot;
    cfg_word[ENABLE_BIT] = enable_state;
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (cfg_hit)
      next_prdata = cfg_word;
    else if (status_hit)
      next_prdata = {26'h0, pin_level_valid, result_q,
        enable_request != enable_state};
  end

  // Read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (read_access)
      prdata <= next_prdata;
  end
endmodule : comparator_channel_control

// ===== verification/comparator_channel_checker.sv
// Purpose: Port-level checks of the channel control
// Assumes: Zero-wait APB, core clock seen as core_tick
// Notes: Attached by bind after the module
`timescale 1ns/1ps
module comparator_channel_checker
  import comparator_channel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pslverr,
  input wire logic core_tick,
  input wire logic raw_compare,
  input logic [1:0] plus_input_select,
  input logic [2:0] minus_input_select,
  input logic positive_from_minus,
  input logic negative_from_plus,
  input logic [1:0] speed_select,
  input logic one_shot,
  input logic comparator_enable,
  input logic compare_result
);
  logic [1:0] ticks;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Core ticks since the last configuration write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ticks <= 2'h0;
    else if (psel && penable && pwrite && paddr == CFG_OFFSET)
      ticks <= 2'h0;
    else if (core_tick && ticks != 2'h3)
      ticks <= ticks + 2'h1;
  end
  property p_swap; positive_from_minus == negative_from_plus;
  endproperty
  a_swap: assert property (p_swap) else $error("swap");
  property p_inv; $past(core_tick) && $past(comparator_enable) &&
    comparator_enable |->
    compare_result == ($past(raw_compare) ^ $past(positive_from_minus));
  endproperty
  a_inv: assert property (p_inv) else $error("invert");
  property p_idle; !comparator_enable && !$past(comparator_enable)
    |-> !compare_result; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_lock; comparator_enable |=> $stable({plus_input_select,
    minus_input_select, speed_select, one_shot, positive_from_minus});
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_rsv; psel && !penable && !pwrite && paddr == CFG_OFFSET
    |=> {prdata[14], prdata[11], prdata[7], prdata[4]} == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_rd; psel && !penable && !pwrite && paddr == CFG_OFFSET
    |=> prdata[13:8] == {$past(plus_input_select), 1'h0,
    $past(minus_input_select)} &&
    prdata[3:1] == {$past(speed_select), $past(one_shot)};
  endproperty
  a_rd: assert property (p_rd) else $error("readback");
  property p_tick; $changed(comparator_enable) |-> $past(core_tick);
  endproperty
  a_tick: assert property (p_tick) else $error("tick");
  property p_lat; $changed(comparator_enable) |-> ticks >= 2'h2;
  endproperty
  a_lat: assert property (p_lat) else $error("latency");
  property p_err; psel && penable && paddr != CFG_OFFSET &&
    paddr != STATUS_OFFSET |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped");
endmodule : comparator_channel_checker
bind comparator_channel_control comparator_channel_checker i_checker (.*);

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the channel control
// Assumes: Core clock modelled as a tick every third cycle
// Notes: Inputs driven by non-blocking assignment at pclk rise
`timescale 1ns/1ps
module testbench;
  import comparator_channel_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, core_tick = 0, raw_compare = 1, err;
  logic [1:0] plus_input_select, speed_select;
  logic [2:0] minus_input_select;
  logic positive_from_minus, negative_from_plus, one_shot;
  logic comparator_enable, compare_result, trigger_event;
  int err_total = 0, compares = 0, cyc = 0;
  comparator_channel_control i_comparator_channel_control
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_tick(core_tick), .pin_level_valid(4'h0),
    .raw_compare(raw_compare), .compare_done(1'h0),
    .plus_input_select(plus_input_select),
    .minus_input_select(minus_input_select),
    .positive_from_minus(positive_from_minus),
    .negative_from_plus(negative_from_plus), .speed_select(speed_select),
    .one_shot(one_shot), .comparator_enable(comparator_enable),
    .compare_result(compare_result), .trigger_event(trigger_event)
  );
  // Bus clock
  initial forever #10 pclk = ~pclk;
  // Core ticks and run limit
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    core_tick <= (cyc % 3 == 0);
    if (cyc == 4000)
    begin
      err_total = err_total + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; result left in rd and err
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // Every field code but speed 2 and 3 written with reserved bits set
  task automatic t_fields();
    logic [2:0] k;
    logic [31:0] d;
    for (int i = 0; i < 8; i++)
    begin
      k = 3'(i);
      d = 32'h0000_4890 | {16'h0, k[0], 1'h0, k[1:0], 1'h0, k, 1'h0,
        k[1:0], 2'h0, k[0], k[0], 1'h0};
      apb(1'h1, CFG_OFFSET, d);
      apb(1'h0, CFG_OFFSET, 32'h0);
      chk(rd, d & 32'h0000_B76F);
      chk({plus_input_select, minus_input_select}, {k[1:0], k});
      chk({speed_select, one_shot}, {1'h0, k[0], k[0]});
      chk({positive_from_minus, negative_from_plus}, {2{k[0]}});
    end
  endtask : t_fields
  // Enable change reads old state until synchronised
  task automatic t_on_off(input logic on);
    logic [31:0] d;
    d = 32'h0000_A524 | 32'(on);
    apb(1'h1, CFG_OFFSET, d);
    apb(1'h0, CFG_OFFSET, 32'h0);
    chk(rd[0], !on);
    for (int n = 0; n < 40 && rd[0] !== on; n++)
      apb(1'h0, CFG_OFFSET, 32'h0);
    chk(rd, d);
    chk(comparator_enable, on);
  endtask : t_on_off
  // Trigger on rising inverted result
  task automatic t_watch(input logic raw, input logic exp);
    logic hit;
    hit = 1'h0;
    raw_compare <= raw;
    repeat (8)
    begin
      @(posedge pclk);
      hit = hit | trigger_event;
    end
    chk(hit, exp);
    chk(compare_result, !raw);
  endtask : t_watch
  // Main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, CFG_OFFSET, 32'h0);
    chk(rd, CFG_RESET);
    t_fields();
    t_on_off(1'h1);
    apb(1'h1, CFG_OFFSET, 32'h0000_1263);
    apb(1'h0, CFG_OFFSET, 32'h0);
    chk(rd, 32'h0000_A525);
    t_watch(1'h0, 1'h1);
    t_watch(1'h1, 1'h0);
    t_on_off(1'h0);
    apb(1'h1, CFG_OFFSET, 32'h0);
    apb(1'h0, CFG_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk({err, rd}, {1'h1, 32'h0});
    end_sim();
  end
  task automatic end_sim();
    $display("err_total=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
endmodule : testbench
